// File: include/pwr_seq_pkg.sv
// Constants, state types and helpers shared by both ends of the sensor power link.
// Assumes a single 10 MHz system clock shared by host and sensor logic.
package pwr_seq_pkg;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS    = 100;
  localparam int SUPPLY_SETTLE_US = 500;   // Board dependent, plain default
  localparam int OSC_SETTLE_US    = 2000;  // Crystal dependent, plain default
  localparam int RAIL_STAGGER_US  = 0;     // May be zero
  localparam int CNT_W            = 24;

  // Least time rounded up to whole cycles, never below one cycle
  function automatic logic [CNT_W-1:0] us_to_cycles(input int us);
    int cyc;
    cyc = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return CNT_W'(cyc);
  endfunction

  localparam logic [CNT_W-1:0] SUPPLY_SETTLE_CYC = us_to_cycles(SUPPLY_SETTLE_US);
  localparam logic [CNT_W-1:0] OSC_SETTLE_CYC    = us_to_cycles(OSC_SETTLE_US);
  localparam logic [CNT_W-1:0] RAIL_STAGGER_CYC  = us_to_cycles(RAIL_STAGGER_US);
  localparam logic [CNT_W-1:0] CNT_ONE           = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_ZERO          = 24'h000000;

  // ==========================================================================
  // Serial link
  localparam logic [3:0] SPI_HALF_CYC  = 4'hA;  // Half SCLK period in clk cycles
  localparam logic [3:0] SPI_LAST_BIT  = 4'h7;
  localparam logic [3:0] BIT_ZERO      = 4'h0;
  localparam logic [7:0] CMD_START_PRG = 8'hA5; // Starts the sensor program

  // Pin input indices in the sensor synchroniser
  localparam int PIN_N      = 9;
  localparam int PIN_CGEN   = 0;
  localparam int PIN_RAIL_A = 1;
  localparam int PIN_RAIL_B = 2;
  localparam int PIN_EN     = 3;
  localparam int PIN_XTAL   = 4;
  localparam int PIN_CTRL   = 5;
  localparam int PIN_SS_N   = 6;
  localparam int PIN_SCLK   = 7;
  localparam int PIN_MOSI   = 8;

  // ==========================================================================
  // States
  typedef enum logic [3:0] {
    H_OFF, H_CGEN_ON, H_RAILS_ON, H_SUPPLY_SETTLE, H_OSC_SETTLE,
    H_READY, H_ENABLE_OFF, H_RAILS_OFF, H_STAGGER
  } host_state_t;

  typedef enum logic [2:0] {
    S_IDLE, S_LEAD, S_HIGH, S_LOW, S_GAP
  } spi_state_t;

endpackage

// File: include/sensor_link_if.sv
// Pins between the host sequencer and the radar sensor.
// Resolves the sensor's tristate pins; an idle pin reads low as with a pull-down.
interface sensor_link_if;
  logic clock_gen_supply;
  logic supply_rail_a;
  logic supply_rail_b;
  logic enable;
  logic xtal_run;
  logic ctrl;
  logic ss_n;
  logic sclk;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic irq_o;
  logic irq_oe;
  logic miso_line;
  logic irq_line;

  // ==========================================================================
  // Wire resolution
  assign miso_line = miso_oe ? miso_o : 1'b0;
  assign irq_line  = irq_oe ? irq_o : 1'b0;

  modport host (
    output clock_gen_supply, supply_rail_a, supply_rail_b, enable, xtal_run,
    output ctrl, ss_n, sclk, mosi,
    input  miso_line, irq_line
  );

  modport sensor (
    input  clock_gen_supply, supply_rail_a, supply_rail_b, enable, xtal_run,
    input  ctrl, ss_n, sclk, mosi,
    output miso_o, miso_oe, irq_o, irq_oe
  );
endinterface

// File: logic/sensor_power_host.sv
// Host end: power sequencer for the radar sensor plus a byte-wide mode 0 link master.
// Assumes the sensor end on the other side of sensor_link_if, same clock domain.

module sensor_power_host
  import pwr_seq_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             power_up_req,
  input  wire logic             power_down_req,
  input  wire logic             ctrl_level,
  input  wire logic [CNT_W-1:0] supply_settle_cycles,
  input  wire logic [CNT_W-1:0] osc_settle_cycles,
  input  wire logic [CNT_W-1:0] rail_stagger_cycles,
  input  wire logic             spi_start,
  input  wire logic [7:0]       spi_tx,
  output logic      [7:0]       spi_rx,
  output logic                  spi_done,
  output logic                  spi_ready,
  output logic                  sensor_on,
  output logic                  powered_off,
  output logic                  irq_seen,
  sensor_link_if.host           link
);

  // ==========================================================================
  // Power state machine
  host_state_t      state_q;
  host_state_t      state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  spi_state_t       sp_q;
  wire              cnt_done = (cnt_q == CNT_ZERO);
  wire              spi_idle = (sp_q == S_IDLE);

  always_comb begin
    state_d = state_q;
    case (state_q)
      H_OFF:           if (power_up_req) state_d = H_CGEN_ON;
      H_CGEN_ON:       state_d = H_RAILS_ON;
      H_RAILS_ON:      state_d = H_SUPPLY_SETTLE;
      H_SUPPLY_SETTLE: if (cnt_done) state_d = H_OSC_SETTLE;
      H_OSC_SETTLE:    if (cnt_done) state_d = H_READY;
      H_READY:         if (power_down_req && spi_idle) state_d = H_ENABLE_OFF;
      H_ENABLE_OFF:    state_d = H_RAILS_OFF;
      H_RAILS_OFF:     state_d = H_STAGGER;
      H_STAGGER:       if (cnt_done) state_d = H_OFF;
      default:         state_d = H_OFF;
    endcase
  end

  // Counter loads on entry to a timed state and counts down to zero
  wire entering = (state_d != state_q);

  always_comb begin
    cnt_d = cnt_q;
    if (entering) begin
      case (state_d)
        H_SUPPLY_SETTLE: cnt_d = supply_settle_cycles - CNT_ONE;
        H_OSC_SETTLE:    cnt_d = osc_settle_cycles - CNT_ONE;
        H_STAGGER:       cnt_d = rail_stagger_cycles - CNT_ONE;
        default:         cnt_d = CNT_ZERO;
      endcase
    end else if (!cnt_done) begin
      cnt_d = cnt_q - CNT_ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= H_OFF;
      cnt_q   <= CNT_ZERO;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // ==========================================================================
  // Pin levels, decoded from the next state so pins track state_q
  wire cgen_d  = (state_d != H_OFF);
  wire en_d    = (state_d == H_RAILS_ON) || (state_d == H_SUPPLY_SETTLE)
              || (state_d == H_OSC_SETTLE) || (state_d == H_READY);
  wire rails_d = en_d || (state_d == H_ENABLE_OFF);
  wire xtal_d  = (state_d == H_OSC_SETTLE) || (state_d == H_READY);
  wire ready_d = (state_d == H_READY);
  // Control pin stays low outside the ready state: settle and shutdown
  wire ctrl_d  = ready_d && ctrl_level;

  // ==========================================================================
  // Link master, mode 0, one byte per select
  logic [3:0] ph_q;
  logic [3:0] bit_q;
  logic [7:0] tx_sh_q;
  logic [7:0] rx_sh_q;
  logic       ss_n_q;
  logic       sclk_q;
  logic       mosi_q;
  logic [2:0] miso_s_q;
  logic [2:0] irq_s_q;
  logic       miso_lvl_q;
  logic       irq_lvl_q;

  wire ph_done   = (ph_q == BIT_ZERO);
  wire ph_next_z = ph_done;
  wire start_ok  = (state_q == H_READY) && spi_start && spi_idle;
  wire last_bit  = (bit_q == SPI_LAST_BIT);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sp_q     <= S_IDLE;
      ph_q     <= BIT_ZERO;
      bit_q    <= BIT_ZERO;
      tx_sh_q  <= 8'h00;
      rx_sh_q  <= 8'h00;
      sclk_q   <= 1'b0;
      mosi_q   <= 1'b0;
      spi_rx   <= 8'h00;
      spi_done <= 1'b0;
    end else begin
      spi_done <= 1'b0;
      if (!ph_next_z) begin
        ph_q <= ph_q - 4'h1;
      end
      case (sp_q)
        S_IDLE: if (start_ok) begin
          tx_sh_q <= spi_tx;
          mosi_q  <= spi_tx[7];
          bit_q   <= BIT_ZERO;
          ph_q    <= SPI_HALF_CYC - 4'h1;
          sp_q    <= S_LEAD;
        end
        S_LEAD, S_LOW: if (ph_done) begin
          sclk_q  <= 1'b1;
          rx_sh_q <= {rx_sh_q[6:0], miso_lvl_q};
          ph_q    <= SPI_HALF_CYC - 4'h1;
          sp_q    <= S_HIGH;
        end
        S_HIGH: if (ph_done) begin
          sclk_q <= 1'b0;
          ph_q   <= SPI_HALF_CYC - 4'h1;
          if (last_bit) begin
            mosi_q <= 1'b0;
            sp_q   <= S_GAP;
          end else begin
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
            mosi_q  <= tx_sh_q[6];
            bit_q   <= bit_q + 4'h1;
            sp_q    <= S_LOW;
          end
        end
        S_GAP: if (ph_done) begin
          spi_rx   <= rx_sh_q;
          spi_done <= 1'b1;
          sp_q     <= S_IDLE;
        end
        default: sp_q <= S_IDLE;
      endcase
    end
  end

  // Select is low only during a transfer; released in the gap. With enable low it
  // is also driven low, so only a transfer started in the cycle power_down_req is taken can leave sclk or mosi high once the clock rail drops.
  wire ss_n_d = en_d && !((sp_q == S_LEAD) || (sp_q == S_HIGH) || (sp_q == S_LOW)
              || (start_ok));

  // ==========================================================================
  // Pin inputs: three stages, level taken once stages two and three agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      miso_s_q   <= 3'h0;
      irq_s_q    <= 3'h0;
      miso_lvl_q <= 1'b0;
      irq_lvl_q  <= 1'b0;
    end else begin
      miso_s_q <= {miso_s_q[1:0], link.miso_line};
      irq_s_q  <= {irq_s_q[1:0], link.irq_line};
      if (miso_s_q[1] == miso_s_q[2]) begin
        miso_lvl_q <= miso_s_q[2];
      end
      if (irq_s_q[1] == irq_s_q[2]) begin
        irq_lvl_q <= irq_s_q[2];
      end
    end
  end

  // ==========================================================================
  // Output registers
  logic cgen_q;
  logic rails_q;
  logic en_q;
  logic xtal_q;
  logic ctrl_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cgen_q      <= 1'b0;
      rails_q     <= 1'b0;
      en_q        <= 1'b0;
      xtal_q      <= 1'b0;
      ctrl_q      <= 1'b0;
      ss_n_q      <= 1'b0;
      spi_ready   <= 1'b0;
      sensor_on   <= 1'b0;
      powered_off <= 1'b1;
      irq_seen    <= 1'b0;
    end else begin
      cgen_q      <= cgen_d;
      rails_q     <= rails_d;
      en_q        <= en_d;
      xtal_q      <= xtal_d;
      ctrl_q      <= ctrl_d;
      ss_n_q      <= ss_n_d;
      spi_ready   <= ready_d && (sp_q == S_IDLE) && !start_ok;
      sensor_on   <= (state_d == H_OSC_SETTLE) || ready_d;
      powered_off <= (state_d == H_OFF);
      irq_seen    <= irq_lvl_q;
    end
  end

  assign link.clock_gen_supply = cgen_q;
  assign link.supply_rail_a    = rails_q;
  assign link.supply_rail_b    = rails_q;
  assign link.enable           = en_q;
  assign link.xtal_run         = xtal_q;
  assign link.ctrl             = ctrl_q;
  assign link.ss_n             = ss_n_q;
  assign link.sclk             = sclk_q;
  assign link.mosi             = mosi_q;

endmodule // sensor_power_host

// File: logic/sensor_power_dev.sv
// Sensor end: power-state tracking, oscillator gate, link slave and interrupt pin.
// Assumes the host end drives every input pin; all pins are sampled as asynchronous.
module sensor_power_dev
  import pwr_seq_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] tx_byte,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            powered_on,
  output logic            osc_running,
  output logic            program_running,
  output logic            deep_idle,
  sensor_link_if.sensor   link
);

  // ==========================================================================
  // Pin synchroniser: stage one feeds stage two only
  logic [PIN_N-1:0] s1_q;
  logic [PIN_N-1:0] s2_q;
  logic [PIN_N-1:0] s3_q;
  logic [PIN_N-1:0] lvl_q;
  logic [PIN_N-1:0] prev_q;

  wire [PIN_N-1:0] pins = {link.mosi, link.sclk, link.ss_n, link.ctrl, link.xtal_run,
                           link.enable, link.supply_rail_b, link.supply_rail_a,
                           link.clock_gen_supply};
  wire [PIN_N-1:0] agree = ~(s2_q ^ s3_q);
  wire [PIN_N-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      lvl_q  <= '0;
      prev_q <= '0;
    end else begin
      s1_q   <= pins;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      lvl_q  <= lvl_d;
      prev_q <= lvl_q;
    end
  end

  // ==========================================================================
  // Power state
  wire en      = lvl_q[PIN_EN];
  wire pwr_d   = lvl_q[PIN_CGEN] && lvl_q[PIN_RAIL_A] && lvl_q[PIN_RAIL_B] && en;
  wire osc_d   = pwr_d && lvl_q[PIN_XTAL];
  wire ss_act  = !lvl_q[PIN_SS_N] && osc_running;
  wire ss_fall = prev_q[PIN_SS_N] && !lvl_q[PIN_SS_N];
  wire sck_ris = !prev_q[PIN_SCLK] && lvl_q[PIN_SCLK];
  wire sck_fal = prev_q[PIN_SCLK] && !lvl_q[PIN_SCLK];

  // ==========================================================================
  // Link slave, mode 0
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic [3:0] bit_q;
  logic       miso_q;
  logic       irq_q;
  wire        byte_end = ss_act && sck_ris && (bit_q == SPI_LAST_BIT);
  wire [7:0]  rx_full  = {rx_sh_q[6:0], lvl_q[PIN_MOSI]};

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_sh_q <= 8'h00;
      tx_sh_q <= 8'h00;
      bit_q   <= BIT_ZERO;
      miso_q  <= 1'b0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= byte_end;
      if (ss_act && ss_fall) begin
        bit_q   <= BIT_ZERO;
        tx_sh_q <= tx_byte;
        miso_q  <= tx_byte[7];
      end else if (ss_act && sck_ris) begin
        rx_sh_q <= rx_full;
        bit_q   <= bit_q + 4'h1;
        if (byte_end) begin
          rx_byte <= rx_full;
          bit_q   <= BIT_ZERO;
        end
      end else if (ss_act && sck_fal) begin
        tx_sh_q <= {tx_sh_q[6:0], 1'b0};
        miso_q  <= tx_sh_q[6];
      end
    end
  end

  // ==========================================================================
  // Program and interrupt pin; program state is lost when enable falls
  always_ff @(posedge clk) begin
    if (!nrst) begin
      powered_on      <= 1'b0;
      osc_running     <= 1'b0;
      program_running <= 1'b0;
      deep_idle       <= 1'b0;
      irq_q           <= 1'b0;
    end else begin
      powered_on  <= pwr_d;
      osc_running <= osc_d;
      if (!en) begin
        program_running <= 1'b0;
      end else if (byte_end && rx_full == CMD_START_PRG) begin
        program_running <= 1'b1;
      end
      deep_idle <= program_running && lvl_q[PIN_CTRL];
      // Event set wins over the select-driven clear
      if (!program_running) begin
        irq_q <= 1'b0;
      end else if (byte_end) begin
        irq_q <= 1'b1;
      end else if (ss_act && ss_fall) begin
        irq_q <= 1'b0;
      end
    end
  end

  assign link.irq_o   = irq_q;
  assign link.irq_oe  = program_running;
  assign link.miso_o  = miso_q;
  assign link.miso_oe = ss_act;

endmodule // sensor_power_dev

// File: test/radar_sensor_power_sequencer_assertions.sv
// Concurrent checks on the pins between the host and sensor ends.
// Assumes one clock domain and the link signals wired in by name.
module pwr_link_assertions (
  input wire logic clk,
  input wire logic nrst,
  input wire logic clock_gen_supply,
  input wire logic supply_rail_a,
  input wire logic supply_rail_b,
  input wire logic enable,
  input wire logic xtal_run,
  input wire logic ctrl,
  input wire logic ss_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic irq_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Clocking
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // ==========================================================
  // Power order
  chk_cgen_first: assert property (
    ($rose(supply_rail_a) || $rose(enable)) |-> clock_gen_supply
  ) else $error("rail or enable rose before clock rail");
  chk_rails_pair: assert property (
    supply_rail_a == supply_rail_b
  ) else $error("rails split");
  chk_powered_run: assert property (
    xtal_run |-> enable && supply_rail_a && clock_gen_supply
  ) else $error("clock running without full power");
  chk_ctrl_settle: assert property (
    ctrl |-> $past(xtal_run)
  ) else $error("control pin high during supply settle");
  chk_idle_pins: assert property (
    !enable |-> !xtal_run && !sclk && !ctrl
  ) else $error("sensor inputs active while enable low");
  chk_irq_float: assert property (
    $rose(irq_oe) |-> enable && supply_rail_a && xtal_run
  ) else $error("interrupt driven without running sensor");
  chk_enable_first: assert property (
    $fell(supply_rail_a) |-> !enable && !$past(enable)
  ) else $error("rails removed before enable low");
  chk_cgen_last: assert property (
    $fell(clock_gen_supply) |-> !supply_rail_a && !enable && !ss_n && !sclk && !mosi && !ctrl
  ) else $error("clock rail off with other pins up");

  // ==========================================================
  // Serial link
  chk_mosi_hold: assert property (
    sclk |-> !ss_n && $stable(mosi)
  ) else $error("data moved while clock high or unselected");
  chk_sclk_high: assert property (
    $rose(sclk) |-> sclk [*8] ##1 sclk ##1 sclk ##1 !sclk
  ) else $error("clock high phase not ten cycles");
endmodule // pwr_link_assertions

// File: test/radar_sensor_power_sequencer_tb.sv
// Self-checking bench joining the host and sensor ends over one link.
// Assumes the package and link interface are compiled first.
module radar_sensor_power_sequencer_tb
  import pwr_seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic             clk;
  logic             nrst;
  logic             power_up_req;
  logic             power_down_req;
  logic             ctrl_level;
  logic [CNT_W-1:0] s_cyc;
  logic [CNT_W-1:0] o_cyc;
  logic [CNT_W-1:0] t_cyc;
  logic             spi_start;
  logic [7:0]       spi_tx;
  logic [7:0]       spi_rx;
  logic [7:0]       tx_byte;
  logic [7:0]       rx_byte;
  logic             spi_done;
  logic             spi_ready;
  logic             sensor_on;
  logic             powered_off;
  logic             irq_seen;
  logic             rx_valid;
  logic             powered_on;
  logic             osc_running;
  logic             program_running;
  logic             deep_idle;
  int               n_mismatch = 0;
  int               num_checks = 0;
  int               cycles = 0;
  sensor_link_if link();

  sensor_power_host i_sensor_power_host (
    .clk(clk), .nrst(nrst), .power_up_req(power_up_req), .power_down_req(power_down_req),
    .ctrl_level(ctrl_level), .supply_settle_cycles(s_cyc), .osc_settle_cycles(o_cyc),
    .rail_stagger_cycles(t_cyc), .spi_start(spi_start), .spi_tx(spi_tx), .spi_rx(spi_rx),
    .spi_done(spi_done), .spi_ready(spi_ready), .sensor_on(sensor_on),
    .powered_off(powered_off), .irq_seen(irq_seen), .link(link));
  sensor_power_dev i_sensor_power_dev (
    .clk(clk), .nrst(nrst), .tx_byte(tx_byte), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .powered_on(powered_on), .osc_running(osc_running), .program_running(program_running),
    .deep_idle(deep_idle), .link(link));
  pwr_link_assertions i_pwr_link_assertions (
    .clk(clk), .nrst(nrst), .clock_gen_supply(link.clock_gen_supply),
    .supply_rail_a(link.supply_rail_a), .supply_rail_b(link.supply_rail_b),
    .enable(link.enable), .xtal_run(link.xtal_run), .ctrl(link.ctrl), .ss_n(link.ss_n),
    .sclk(link.sclk), .mosi(link.mosi), .irq_oe(link.irq_oe));

  // ==========================================================
  // Clock and hang guard, about five times the expected run
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_mismatch = n_mismatch + 1;
      end_sim();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Pins that must sit low while the sequencer is off, all but supply_rail_b and mosi, plus powered_on low and powered_off high
  function automatic logic [9:0] off_pins();
    return {link.clock_gen_supply, link.supply_rail_a, link.enable, link.xtal_run, link.ctrl,
            link.ss_n, link.sclk, link.irq_oe, powered_off, powered_on};
  endfunction
  // Checked in reset and again two cycles after release, where a stray pin would first show
  task automatic t_reset(input int n);
    nrst <= 1'b0;
    repeat (n) @(posedge clk);
    chk(off_pins(), 10'h002);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    chk(off_pins(), 10'h002);
  endtask
  // Counts stay programmable, so each run uses its own figures
  task automatic t_power_up(input logic [CNT_W-1:0] s, input logic [CNT_W-1:0] o);
    int c, t_cg, t_ra, t_en, t_x, t_r;
    t_cg = -1;
    t_ra = -1;
    t_en = -1;
    t_x = -1;
    t_r = -1;
    s_cyc <= s;
    o_cyc <= o;
    power_up_req <= 1'b1;
    @(posedge clk);
    power_up_req <= 1'b0;
    for (c = 0; c < 300 && t_r < 0; c++) begin
      @(posedge clk);
      if (t_cg < 0 && link.clock_gen_supply === 1'b1) t_cg = c;
      if (t_ra < 0 && link.supply_rail_a === 1'b1) t_ra = c;
      if (t_en < 0 && link.enable === 1'b1) t_en = c;
      if (t_x < 0 && link.xtal_run === 1'b1) t_x = c;
      if (t_r < 0 && spi_ready === 1'b1) t_r = c;
      if (link.xtal_run !== 1'b1) chk(link.ctrl, 1'b0);
    end
    chk(t_ra - t_cg, 32'h1);
    chk(t_en - t_ra, 32'h0);
    chk(t_x - t_ra, 32'(s) + 32'h1);
    chk(t_r - t_x, 32'(o));
    repeat (6) @(posedge clk);
    chk({powered_on, osc_running, sensor_on, link.ctrl}, {3'h7, ctrl_level});
  endtask
  task automatic t_spi(input logic [7:0] tx, input logic [7:0] reply);
    int c, rises;
    logic [7:0] got;
    logic prev;
    rises = 0;
    got = 8'h00;
    prev = 1'b0;
    for (c = 0; c < 50 && spi_ready !== 1'b1; c++) @(posedge clk);
    tx_byte <= reply;
    spi_tx <= tx;
    spi_start <= 1'b1;
    @(posedge clk);
    spi_start <= 1'b0;
    for (c = 0; c < 400 && spi_done !== 1'b1; c++) begin
      @(posedge clk);
      if (link.sclk === 1'b1 && prev === 1'b0) rises++;
      prev = link.sclk;
      if (rx_valid === 1'b1) got = rx_byte;
    end
    chk({spi_rx, got}, {reply, tx});
    chk({rises[7:0], link.ss_n}, {8'h08, 1'b1});
  endtask
  task automatic t_program();
    t_spi(8'h3C, 8'hC3);
    chk({link.irq_oe, program_running}, 2'h0);
    t_spi(CMD_START_PRG, 8'h5A);
    t_spi(8'h81, 8'h18);
    repeat (8) @(posedge clk);
    chk({link.irq_oe, program_running, irq_seen, deep_idle}, 4'hF);
    ctrl_level <= 1'b0;
    repeat (8) @(posedge clk);
    chk({link.ctrl, deep_idle}, 2'h0);
  endtask
  task automatic t_power_down(input logic [CNT_W-1:0] t);
    int c, t_en, t_ra, t_cg;
    t_en = -1;
    t_ra = -1;
    t_cg = -1;
    t_cyc <= t;
    power_down_req <= 1'b1;
    @(posedge clk);
    power_down_req <= 1'b0;
    for (c = 0; c < 100 && t_cg < 0; c++) begin
      @(posedge clk);
      if (t_en < 0 && link.enable === 1'b0) t_en = c;
      if (t_ra < 0 && link.supply_rail_a === 1'b0) t_ra = c;
      if (t_cg < 0 && link.clock_gen_supply === 1'b0) t_cg = c;
    end
    chk(t_ra - t_en, 32'h1);
    chk(t_cg - t_ra, 32'(t) + 32'h1);
    repeat (6) @(posedge clk);
    chk({osc_running, powered_on, powered_off}, 3'h1);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    power_up_req = 1'b0;
    power_down_req = 1'b0;
    ctrl_level = 1'b1;
    s_cyc = 24'h000005;
    o_cyc = 24'h000005;
    t_cyc = 24'h000001;
    spi_start = 1'b0;
    spi_tx = 8'h00;
    tx_byte = 8'h00;
    @(posedge clk);
    t_reset(19);
    t_power_up(24'h00000C, 24'h000014);
    t_program();
    t_power_down(24'h000007);
    ctrl_level <= 1'b1;
    t_power_up(24'h000001, 24'h000001);
    t_spi(8'hFF, 8'h00);
    t_power_down(24'h000001);
    t_power_up(24'h000003, 24'h000002);
    t_reset(2);
    end_sim();
  end
endmodule // radar_sensor_power_sequencer_tb
